//--- design/dso_top.v
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dso_consts.vh"
module dso_top #(
  parameter NOUT = 4,
  parameter [15:0] MAX_FREQ = `DSO_FREQ_MAX_CT,
  parameter [23:0] POWER_OFF_CYC = `DSO_POWER_OFF_CYC,
  parameter [23:0] SEC_CYC = `DSO_SEC_CYC
) (
  input wire clock,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire motorRunning,
  input wire speedAboveZero,
  input wire dcInjActive,
  input wire phaseFwd,
  input wire keypadCmd,
  input wire autoMode,
  input wire jogCmd,
  input wire jogInputAssigned,
  input wire driveThermAlarm,
  input wire [15:0] driveCurPct,
  input wire [15:0] outFreqHz,
  input wire [15:0] motorThermPct,
  input wire [15:0] secondCurrentLoopInputUa,
  input wire [15:0] setpointPct,
  input wire [15:0] feedbackPct,
  input wire [15:0] motorCurPermil,
  input wire [15:0] speedNoSlip,
  input wire [`DSO_FLT_W-1:0] faultCause,
  input wire powerPresent,
  input wire inputPhaseLoss,
  input wire faultResetInput,
  input wire faultResetKey,
  output wire [NOUT-1:0] logicOut,
  output wire dedicatedFaultRelay,
  output wire faultActive,
  output wire stopRamp,
  output wire stopFast,
  output wire stopCoast,
  output wire [11:0] aoMotorCurrent,
  output wire [11:0] aoMotorSpeed
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [15:0] clampU;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clampU = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [11:0] aoScale;
    input [15:0] v;
    input [15:0] fs;
    input off4;
    reg [15:0] lim;
    reg [11:0] base;
    reg [11:0] span;
    reg [27:0] prod;
    reg [27:0] quot;
    begin
      lim = (v > fs) ? fs : v;
      base = off4 ? `DSO_AO_4MA : 12'h000;
      span = off4 ? (`DSO_AO_FS - `DSO_AO_4MA) : `DSO_AO_FS;
      prod = lim * span;
      quot = 28'h0000000;
      if (fs == 16'h0000)
        aoScale = base;
      else begin
        quot = prod / fs;
        aoScale = base + quot[11:0];
      end
    end
  endfunction

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  reg pready_r;
  reg pslverr_r;
  reg [31:0] prdata_r;
  reg [10:0] ctrl_r;
  reg [15:0] freqLvl_r;
  reg [15:0] curLvl_r;
  reg [15:0] thermLvl_r;
  reg [15:0] curLim_r;
  reg [15:0] errLim_r;
  reg [9:0] rstDelay_r;
  reg [4*NOUT-1:0] outSel_r;
  reg [15:0] highSpeed_r;
  reg [`DSO_FLT_W-1:0] faultLatch_r;
  reg [2:0] tries_r;
  reg [2:0] state_r;
  reg [1:0] stopMode_r;
  reg faultState_r;
  wire [5:0] regIdx = paddr[7:2];
  wire access = psel & penable & pready_r;
  wire wrEn = access & pwrite;
  wire rdEn = access & ~pwrite;
  wire varTq = ctrl_r[`DSO_CTRL_VARTQ];
  wire [15:0] freqMax = varTq ? `DSO_FREQ_MAX_VT : MAX_FREQ;
  wire [15:0] curMax = varTq ? `DSO_CURL_MAX_VT : `DSO_CURL_MAX_CT;
  wire [1:0] wStop = pwdata[`DSO_CTRL_STOP];
  reg [31:0] rdMux;
  reg rdBad;

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  always @* begin
    rdBad = 1'b0;
    rdMux = 32'h0000_0000;
    case (regIdx)
      `DSO_OFF_CTRL: rdMux = {21'h000000, ctrl_r};
      `DSO_OFF_FREQ: rdMux = {16'h0000, freqLvl_r};
      `DSO_OFF_CURL: rdMux = {16'h0000, curLvl_r};
      `DSO_OFF_THRM: rdMux = {16'h0000, thermLvl_r};
      `DSO_OFF_CLIM: rdMux = {16'h0000, curLim_r};
      `DSO_OFF_ERRL: rdMux = {16'h0000, errLim_r};
      `DSO_OFF_RDLY: rdMux = {22'h000000, rstDelay_r};
      `DSO_OFF_OSEL: rdMux[4*NOUT-1:0] = outSel_r;
      `DSO_OFF_HSPD: rdMux = {16'h0000, highSpeed_r};
      `DSO_OFF_STAT:
        rdMux = {22'h000000, state_r, tries_r, stopMode_r,
                 1'b0, faultState_r};
      `DSO_OFF_FLT: rdMux = {8'h00, faultLatch_r};
      default: rdBad = 1'b1;
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & rdBad;
      if (psel & penable & ~pready_r & ~pwrite)
        prdata_r <= rdMux;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      ctrl_r <= `DSO_CTRL_RST;
      freqLvl_r <= 16'h0000;
      curLvl_r <= `DSO_CURL_MIN;
      thermLvl_r <= `DSO_THRM_MAX;
      curLim_r <= `DSO_CURL_MAX_CT;
      errLim_r <= `DSO_ERRL_MAX;
      rstDelay_r <= `DSO_RDLY_RST;
      outSel_r <= `DSO_OSEL_RST;
      highSpeed_r <= `DSO_HSPD_RST;
    end else if (wrEn) begin
      case (regIdx)
        `DSO_OFF_CTRL: begin
          ctrl_r <= pwdata[10:0];
          if (wStop == 2'h3)
            ctrl_r[`DSO_CTRL_STOP] <= `DSO_STOP_FREE;
          if (pwdata[6:4] == 3'h0)
            ctrl_r[`DSO_CTRL_TRIES] <= 3'h1;
          else if (pwdata[6:4] > 3'h5)
            ctrl_r[`DSO_CTRL_TRIES] <= 3'h5;
        end
        `DSO_OFF_FREQ:
          freqLvl_r <= clampU(pwdata[15:0], 16'h0000, freqMax);
        `DSO_OFF_CURL:
          curLvl_r <= clampU(pwdata[15:0], `DSO_CURL_MIN, curMax);
        `DSO_OFF_THRM:
          thermLvl_r <= clampU(pwdata[15:0], 16'h0000, `DSO_THRM_MAX);
        `DSO_OFF_CLIM: curLim_r <= pwdata[15:0];
        `DSO_OFF_ERRL:
          errLim_r <= clampU(pwdata[15:0], 16'h0000, `DSO_ERRL_MAX);
        `DSO_OFF_RDLY:
          rstDelay_r <= (pwdata[9:0] == 10'h000) ? 10'h001 : pwdata[9:0];
        `DSO_OFF_OSEL: outSel_r <= pwdata[4*NOUT-1:0];
        `DSO_OFF_HSPD: highSpeed_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Level comparators
  // ----------------------------------------
  wire freqHit;
  wire curLvlHit;
  wire thermHit;
  wire curLimHit;
  wire fbLimHit;
  wire [15:0] errAbs = (setpointPct > feedbackPct) ?
                       (setpointPct - feedbackPct) :
                       (feedbackPct - setpointPct);

  dso_level_cmp #(.W(16), .SET_AT_EQ(0)) uFreq (
    .clock(clock), .reset(reset), .value(outFreqHz),
    .level(freqLvl_r), .hit(freqHit));
  dso_level_cmp #(.W(16), .SET_AT_EQ(0)) uCurLvl (
    .clock(clock), .reset(reset), .value(driveCurPct),
    .level(curLvl_r), .hit(curLvlHit));
  dso_level_cmp #(.W(16), .SET_AT_EQ(1)) uTherm (
    .clock(clock), .reset(reset), .value(motorThermPct),
    .level(thermLvl_r), .hit(thermHit));
  dso_level_cmp #(.W(16), .SET_AT_EQ(1)) uCurLim (
    .clock(clock), .reset(reset), .value(driveCurPct),
    .level(curLim_r), .hit(curLimHit));
  dso_level_cmp #(.W(16), .SET_AT_EQ(0)) uFbLim (
    .clock(clock), .reset(reset), .value(errAbs),
    .level(errLim_r), .hit(fbLimHit));

  // ----------------------------------------
  // Function vector and outputs
  // ----------------------------------------
  wire moving = motorRunning & speedAboveZero & ~dcInjActive;
  wire [15:0] funcVec;
  assign funcVec[0] = 1'b0;
  assign funcVec[`DSO_FN_FWD] = moving & phaseFwd;
  assign funcVec[`DSO_FN_REV] = moving & ~phaseFwd;
  assign funcVec[`DSO_FN_KEYPAD] = keypadCmd;
  assign funcVec[`DSO_FN_AUTO] = autoMode;
  assign funcVec[`DSO_FN_CLIM] = curLimHit;
  assign funcVec[`DSO_FN_FAULT] = faultState_r;
  assign funcVec[`DSO_FN_THALM] = driveThermAlarm;
  assign funcVec[`DSO_FN_LOSSF] = ctrl_r[`DSO_CTRL_AI2MA] &
    (secondCurrentLoopInputUa < `DSO_AI2_LOSS_UA);
  assign funcVec[`DSO_FN_FREQ] = freqHit;
  assign funcVec[`DSO_FN_CURL] = curLvlHit;
  assign funcVec[`DSO_FN_THRM] = thermHit;
  assign funcVec[`DSO_FN_JOG] = jogCmd & jogInputAssigned;
  assign funcVec[`DSO_FN_FBLIM] = fbLimHit;
  assign funcVec[15:14] = 2'h0;

  dso_out_sel #(.NOUT(NOUT)) uSel (
    .clock(clock), .reset(reset), .funcVec(funcVec),
    .sel(outSel_r), .outs(logicOut));

  // ----------------------------------------
  // Supply loss detection
  // ----------------------------------------
  reg [23:0] offCnt_r;
  reg manualRst_r;
  wire supplyLost = ~powerPresent |
    (ctrl_r[`DSO_CTRL_PHDET] & inputPhaseLoss);
  wire offLong = (offCnt_r > POWER_OFF_CYC);

  always @(posedge clock) begin
    if (reset) begin
      offCnt_r <= 24'h000000;
      manualRst_r <= 1'b0;
    end else begin
      manualRst_r <= ~supplyLost & offLong;
      if (supplyLost & ~offLong)
        offCnt_r <= offCnt_r + 24'h000001;
      else if (~supplyLost)
        offCnt_r <= 24'h000000;
    end
  end

  // ----------------------------------------
  // Automatic restart sequencer
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_LOCK = 3'b100;
  reg [23:0] secCnt_r;
  reg [9:0] dlyCnt_r;
  wire secTick = (secCnt_r == SEC_CYC - 24'h000001);
  wire autoOk = ctrl_r[`DSO_CTRL_AUTOEN] &
    ctrl_r[`DSO_CTRL_TWOWIRE];
  wire onlyAuto = (faultLatch_r != 24'h000000) &
    ((faultLatch_r & ~`DSO_AUTO_MASK) == 24'h000000);
  wire autoTry = (state_r == ST_WAIT) & (dlyCnt_r == 10'h000);
  wire allGone = ((faultLatch_r & faultCause) == 24'h000000);

  always @(posedge clock) begin
    if (reset)
      secCnt_r <= 24'h000000;
    else if (secTick)
      secCnt_r <= 24'h000000;
    else
      secCnt_r <= secCnt_r + 24'h000001;
  end

  always @(posedge clock) begin
    if (reset) begin
      state_r <= ST_IDLE;
      tries_r <= 3'h0;
      dlyCnt_r <= 10'h000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          tries_r <= 3'h0;
          if (onlyAuto & autoOk) begin
            state_r <= ST_WAIT;
            dlyCnt_r <= rstDelay_r;
          end
        end
        ST_WAIT: begin
          if (~autoOk | ~onlyAuto)
            state_r <= ST_IDLE;
          else if (autoTry) begin
            if (allGone)
              state_r <= ST_IDLE;
            else if (tries_r + 3'h1 >= ctrl_r[`DSO_CTRL_TRIES]) begin
              tries_r <= tries_r + 3'h1;
              state_r <= ST_LOCK;
            end else begin
              tries_r <= tries_r + 3'h1;
              dlyCnt_r <= rstDelay_r;
            end
          end else if (secTick)
            dlyCnt_r <= dlyCnt_r - 10'h001;
        end
        ST_LOCK: begin
          if (faultLatch_r == 24'h000000)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Fault latch and reset sources
  // ----------------------------------------
  wire userRst = faultResetInput | faultResetKey;
  wire [`DSO_FLT_W-1:0] allow =
    (manualRst_r ? 24'hFFFFFF : 24'h000000) |
    (userRst ? ~`DSO_POWER_ONLY_MASK : 24'h000000) |
    (autoTry ? `DSO_AUTO_MASK : 24'h000000);
  wire [`DSO_FLT_W-1:0] clrMask = allow & ~faultCause;
  wire [`DSO_FLT_W-1:0] latchNxt = (faultLatch_r & ~clrMask) |
    (faultCause & ~`DSO_NONLATCH_MASK);
  wire faultNxt = (latchNxt != 24'h000000) |
    ((faultCause & `DSO_NONLATCH_MASK) != 24'h000000);
  reg faultRelay_r;
  reg stopRamp_r;
  reg stopFast_r;
  reg stopCoast_r;

  always @(posedge clock) begin
    if (reset) begin
      faultLatch_r <= 24'h000000;
      faultState_r <= 1'b0;
      faultRelay_r <= 1'b0;
    end else begin
      faultLatch_r <= latchNxt;
      faultState_r <= faultNxt;
      faultRelay_r <= ~faultNxt;
    end
  end

  // ----------------------------------------
  // Fault stop method
  // ----------------------------------------
  wire forceFree = ((faultCause & `DSO_FREEWHEEL_MASK) != 24'h000000) |
    ((faultLatch_r & `DSO_FREEWHEEL_MASK) != 24'h000000);
  wire [1:0] stopSel = forceFree ? `DSO_STOP_FREE :
    ctrl_r[`DSO_CTRL_STOP];

  always @(posedge clock) begin
    if (reset) begin
      stopMode_r <= `DSO_STOP_FREE;
      stopRamp_r <= 1'b0;
      stopFast_r <= 1'b0;
      stopCoast_r <= 1'b0;
    end else begin
      if (faultNxt & (~faultState_r | forceFree))
        stopMode_r <= stopSel;
      stopRamp_r <= faultNxt & ~forceFree &
        ((faultState_r ? stopMode_r : stopSel) == `DSO_STOP_NORMAL);
      stopFast_r <= faultNxt & ~forceFree &
        ((faultState_r ? stopMode_r : stopSel) == `DSO_STOP_FAST);
      stopCoast_r <= faultNxt & (forceFree |
        ((faultState_r ? stopMode_r : stopSel) == `DSO_STOP_FREE));
    end
  end

  // ----------------------------------------
  // Analog outputs
  // ----------------------------------------
  reg [11:0] aoCur_r;
  reg [11:0] aoSpd_r;

  always @(posedge clock) begin
    if (reset) begin
      aoCur_r <= 12'h000;
      aoSpd_r <= 12'h000;
    end else begin
      aoCur_r <= aoScale(motorCurPermil, `DSO_CUR_FS,
                         ctrl_r[`DSO_CTRL_AO4MA]);
      aoSpd_r <= aoScale(speedNoSlip, highSpeed_r,
                         ctrl_r[`DSO_CTRL_AO4MA]);
    end
  end

  assign dedicatedFaultRelay = faultRelay_r;
  assign faultActive = faultState_r;
  assign stopRamp = stopRamp_r;
  assign stopFast = stopFast_r;
  assign stopCoast = stopCoast_r;
  assign aoMotorCurrent = aoCur_r;
  assign aoMotorSpeed = aoSpd_r;
endmodule // dso_top
`default_nettype wire

//--- shared/dso_consts.vh
`ifndef DSO_CONSTS_VH
`define DSO_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DSO_OFF_CTRL 6'h00
`define DSO_OFF_FREQ 6'h01
`define DSO_OFF_CURL 6'h02
`define DSO_OFF_THRM 6'h03
`define DSO_OFF_CLIM 6'h04
`define DSO_OFF_ERRL 6'h05
`define DSO_OFF_RDLY 6'h06
`define DSO_OFF_OSEL 6'h07
`define DSO_OFF_HSPD 6'h08
`define DSO_OFF_STAT 6'h09
`define DSO_OFF_FLT 6'h0A
// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define DSO_CTRL_STOP 1:0
`define DSO_CTRL_TWOWIRE 2
`define DSO_CTRL_AUTOEN 3
`define DSO_CTRL_TRIES 6:4
`define DSO_CTRL_PHDET 7
`define DSO_CTRL_AI2MA 8
`define DSO_CTRL_AO4MA 9
`define DSO_CTRL_VARTQ 10
`define DSO_CTRL_RST 11'h012
`define DSO_STOP_NORMAL 2'h0
`define DSO_STOP_FAST 2'h1
`define DSO_STOP_FREE 2'h2
`define DSO_OSEL_RST 16'h0000
`define DSO_HSPD_RST 16'h0032
`define DSO_RDLY_RST 10'h001
// ----------------------------------------
// Level ranges
// ----------------------------------------
`define DSO_FREQ_MAX_CT 16'h0190
`define DSO_FREQ_MAX_VT 16'h005A
`define DSO_CURL_MIN 16'h000A
`define DSO_CURL_MAX_CT 16'h0096
`define DSO_CURL_MAX_VT 16'h006E
`define DSO_THRM_MAX 16'h00C8
`define DSO_ERRL_MAX 16'h0064
`define DSO_AI2_LOSS_UA 16'h0BB8
`define DSO_CUR_FS 16'h07D0
`define DSO_AO_FS 12'hFFF
`define DSO_AO_4MA 12'h333
// ----------------------------------------
// Fault classes
// ----------------------------------------
`define DSO_FLT_W 24
`define DSO_FREEWHEEL_MASK 24'h20FFFF
`define DSO_POWER_ONLY_MASK 24'h0007FF
`define DSO_AUTO_MASK 24'h1FF800
`define DSO_NONLATCH_MASK 24'h600000
// ----------------------------------------
// Output function codes
// ----------------------------------------
`define DSO_FN_FWD 1
`define DSO_FN_REV 2
`define DSO_FN_KEYPAD 3
`define DSO_FN_AUTO 4
`define DSO_FN_CLIM 5
`define DSO_FN_FAULT 6
`define DSO_FN_THALM 7
`define DSO_FN_LOSSF 8
`define DSO_FN_FREQ 9
`define DSO_FN_CURL 10
`define DSO_FN_THRM 11
`define DSO_FN_JOG 12
`define DSO_FN_FBLIM 13
// ----------------------------------------
// Timing
// ----------------------------------------
`define DSO_CLK_HZ 10000000
`define DSO_POWER_OFF_MS 1000
`define DSO_POWER_OFF_CYC ((`DSO_CLK_HZ/1000)*`DSO_POWER_OFF_MS)
`define DSO_SEC_CYC `DSO_CLK_HZ
`endif

//--- design/dso_level_cmp.v
`timescale 1ns/1ps
`default_nettype none
module dso_level_cmp #(
  parameter W = 16,
  parameter SET_AT_EQ = 0
) (
  input wire clock,
  input wire reset,
  input wire [W-1:0] value,
  input wire [W-1:0] level,
  output wire hit
);
  reg hit_r;
  wire setHit = SET_AT_EQ ? (value >= level) : (value > level);
  assign hit = hit_r;
  // Holds between set and clear thresholds
  always @(posedge clock) begin
    if (reset)
      hit_r <= 1'b0;
    else if (setHit)
      hit_r <= 1'b1;
    else if (value < level)
      hit_r <= 1'b0;
  end
endmodule // dso_level_cmp
`default_nettype wire

//--- design/dso_out_sel.v
`timescale 1ns/1ps
`default_nettype none
module dso_out_sel #(
  parameter NOUT = 4
) (
  input wire clock,
  input wire reset,
  input wire [15:0] funcVec,
  input wire [4*NOUT-1:0] sel,
  output wire [NOUT-1:0] outs
);
  reg [NOUT-1:0] outs_r;
  integer i;
  assign outs = outs_r;
  // Code 0 is a permanently low output
  always @(posedge clock) begin
    if (reset)
      outs_r <= {NOUT{1'b0}};
    else
      for (i = 0; i < NOUT; i = i + 1)
        outs_r[i] <= funcVec[sel[4*i +: 4]];
  end
endmodule // dso_out_sel
`default_nettype wire

//--- verif/dso_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "dso_consts.vh"
module dso_properties (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] motorCurPermil,
  input wire logic [15:0] speedNoSlip,
  input wire logic [`DSO_FLT_W-1:0] faultCause,
  input wire logic dedicatedFaultRelay,
  input wire logic faultActive,
  input wire logic stopRamp,
  input wire logic stopFast,
  input wire logic stopCoast,
  input wire logic [11:0] aoMotorCurrent,
  input wire logic [11:0] aoMotorSpeed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Fault state and relay
  // ----------------------------------------
  a_relay_inverse: assert property (!$past(reset) |->
    dedicatedFaultRelay == !faultActive) else $error("relay mismatch");
  a_fault_sets: assert property (faultCause != 0 |=> faultActive)
    else $error("fault not raised");
  a_cause_blocks: assert property ($fell(faultActive) |->
    $past(faultCause) == 0) else $error("fault cleared with cause");
  a_stop_onehot: assert property (faultActive |->
    $onehot({stopRamp, stopFast, stopCoast})) else $error("stop not onehot");
  a_idle_no_stop: assert property (!faultActive |->
    !(stopRamp | stopFast | stopCoast)) else $error("stop without fault");
  a_forced_coast: assert property (
    (faultCause & `DSO_FREEWHEEL_MASK) != 0 |=> stopCoast)
    else $error("protective fault not coasting");
  // ----------------------------------------
  // Analog and bus
  // ----------------------------------------
  a_cur_fullscale: assert property (motorCurPermil >= 16'h07D0 |=>
    aoMotorCurrent == 12'hFFF) else $error("current not full scale");
  a_speed_zero: assert property (speedNoSlip == 16'h0000 |=>
    aoMotorSpeed == 12'h000 || aoMotorSpeed == 12'h333)
    else $error("zero speed code wrong");
  a_ready_wait: assert property ($rose(penable) && psel |->
    !pready ##1 pready) else $error("pready timing wrong");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  c_fast: cover property (faultActive && stopFast);
  c_coast: cover property (faultActive && stopCoast);
  c_slverr: cover property (pslverr);
endmodule // dso_properties
bind dso_top dso_properties u_props (
  .clock(clock),
  .reset(reset),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .motorCurPermil(motorCurPermil),
  .speedNoSlip(speedNoSlip),
  .faultCause(faultCause),
  .dedicatedFaultRelay(dedicatedFaultRelay),
  .faultActive(faultActive),
  .stopRamp(stopRamp),
  .stopFast(stopFast),
  .stopCoast(stopCoast),
  .aoMotorCurrent(aoMotorCurrent),
  .aoMotorSpeed(aoMotorSpeed)
);
`default_nettype wire

//--- verif/dso_plant.sv
`timescale 1ns/1ps
`default_nettype none
module dso_plant (
  input wire logic clock,
  input wire logic [3:0] logicOut,
  input wire logic dedicatedFaultRelay,
  output logic [3:0] contact,
  output logic faultLamp
);
  // Contacts follow coils one clock late
  always @(posedge clock) begin
    contact <= logicOut;
    faultLamp <= !dedicatedFaultRelay;
  end
endmodule // dso_plant
`default_nettype wire

//--- verif/dso_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dso_consts.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module dso_top_tb_top;
  typedef struct packed {logic [15:0] osel; logic [9:0] fl; logic [3:0] ex;}
    dso_row_t;
  logic clock, reset, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic er;
  wire [31:0] prdata;
  wire pready, pslverr, dedicatedFaultRelay, faultActive;
  wire stopRamp, stopFast, stopCoast, faultLamp;
  wire [3:0] logicOut, contact;
  wire [11:0] aoMotorCurrent, aoMotorSpeed;
  logic motorRunning, speedAboveZero, dcInjActive, phaseFwd, keypadCmd;
  logic autoMode, jogCmd, jogInputAssigned, driveThermAlarm, powerPresent;
  logic faultResetInput, faultResetKey;
  logic [15:0] driveCurPct, outFreqHz, aiUa, motorCurPermil, speedNoSlip;
  logic [15:0] motorThermPct, setpointPct, feedbackPct;
  wire [2:0] stops = {stopRamp, stopFast, stopCoast};
  logic [23:0] faultCause;
  int n_errors, samples_checked, cycles;
  dso_row_t rows[10] = '{
    {16'h4321, 10'h340, 4'h1}, {16'h4321, 10'h300, 4'h2},
    {16'h4321, 10'h3C0, 4'h0}, {16'h4321, 10'h240, 4'h0},
    {16'h4321, 10'h020, 4'h4}, {16'h4321, 10'h010, 4'h8},
    {16'h0C87, 10'h002, 4'h1}, {16'h0C87, 10'h001, 4'h2},
    {16'h0C87, 10'h00C, 4'h4}, {16'h0C87, 10'h008, 4'h0}};
  logic [15:0] fq[4] = '{16'h0032, 16'h0033, 16'h0032, 16'h0031};
  logic [3:0] fe = 4'b0110;
  dso_top #(.POWER_OFF_CYC(24'h000014), .SEC_CYC(24'h00000A)) dut (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .motorRunning(motorRunning),
    .speedAboveZero(speedAboveZero), .dcInjActive(dcInjActive),
    .phaseFwd(phaseFwd), .keypadCmd(keypadCmd), .autoMode(autoMode),
    .jogCmd(jogCmd), .jogInputAssigned(jogInputAssigned),
    .driveThermAlarm(driveThermAlarm), .driveCurPct(driveCurPct),
    .outFreqHz(outFreqHz), .motorThermPct(motorThermPct),
    .secondCurrentLoopInputUa(aiUa), .setpointPct(setpointPct),
    .feedbackPct(feedbackPct), .motorCurPermil(motorCurPermil),
    .speedNoSlip(speedNoSlip), .faultCause(faultCause),
    .powerPresent(powerPresent), .inputPhaseLoss(1'b0),
    .faultResetInput(faultResetInput), .faultResetKey(faultResetKey),
    .logicOut(logicOut), .dedicatedFaultRelay(dedicatedFaultRelay),
    .faultActive(faultActive), .stopRamp(stopRamp), .stopFast(stopFast),
    .stopCoast(stopCoast), .aoMotorCurrent(aoMotorCurrent),
    .aoMotorSpeed(aoMotorSpeed));
  dso_plant plant (.clock(clock), .logicOut(logicOut),
    .dedicatedFaultRelay(dedicatedFaultRelay), .contact(contact),
    .faultLamp(faultLamp));
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  task conclude;
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task setin(input logic [9:0] f);
    {motorRunning, speedAboveZero, dcInjActive, phaseFwd, keypadCmd,
      autoMode, jogCmd, jogInputAssigned, driveThermAlarm} <= f[9:1];
    aiUa <= f[0] ? 16'h07D0 : 16'h1388;
  endtask
  initial begin
    {reset, powerPresent} = 2'b11;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {faultResetInput, faultResetKey, driveCurPct, outFreqHz} = '0;
    {motorCurPermil, speedNoSlip, faultCause} = '0;
    {motorThermPct, setpointPct, feedbackPct} = '0;
    {motorRunning, speedAboveZero, dcInjActive, phaseFwd, keypadCmd,
      autoMode, jogCmd, jogInputAssigned, driveThermAlarm} = '0;
    aiUa = 16'h1388;
    cyc(6);
    `CHK("relay in reset", 1'b0, dedicatedFaultRelay)
    reset <= 0;
    apb(0, 8'h00, 0); `CHK("ctrl reset", 32'h12, rd)
    apb(0, 8'h20, 0); `CHK("hspd reset", 32'h32, rd)
    apb(0, 8'h1C, 0); `CHK("osel reset", 32'h0, rd)
    apb(0, 8'h3C, 0); `CHK("unmapped err", 1'b1, er)
    apb(1, 8'h00, 32'h112);
    foreach (rows[i]) begin
      apb(1, 8'h1C, {16'h0000, rows[i].osel});
      setin(rows[i].fl);
      cyc(4);
      `CHK("logicOut", rows[i].ex, logicOut)
      `CHK("contact", rows[i].ex, contact)
    end
    setin(10'h000);
    apb(1, 8'h1C, 32'hC956);
    apb(1, 8'h04, 32'h32);
    for (int i = 0; i < 4; i++) begin
      outFreqHz <= fq[i];
      cyc(4);
      `CHK("freq level", fe[i], logicOut[2])
    end
    driveCurPct <= 16'h0096;
    cyc(4); `CHK("cur limit at", 1'b1, logicOut[1])
    driveCurPct <= 16'h0095;
    cyc(4); `CHK("cur limit below", 1'b0, logicOut[1])
    for (int s = 0; s < 4; s++) begin
      apb(1, 8'h00, 32'h110 | s);
      faultCause <= 24'h020000;
      cyc(3);
      `CHK("stop", s > 1 ? 3'h1 : 3'h4 >> s, stops)
      `CHK("fault out", 1'b1, logicOut[0])
      `CHK("fault lamp", 1'b1, faultLamp)
      faultResetInput <= 1;
      cyc(3); `CHK("held fault", 1'b1, faultActive)
      {faultCause, faultResetInput} <= '0;
      cyc(2);
      faultResetInput <= !s[0];
      faultResetKey <= s[0];
      cyc(3);
      {faultResetInput, faultResetKey} <= '0;
      `CHK("fault cleared", 1'b0, faultActive)
      `CHK("relay back", 1'b1, dedicatedFaultRelay)
    end
    apb(1, 8'h00, 32'h110);
    faultCause <= 24'h020000;
    cyc(3);
    faultCause <= 24'h020001;
    cyc(3); `CHK("forced coast", 3'h1, stops)
    faultCause <= '0;
    faultResetInput <= 1;
    cyc(3); `CHK("power-only held", 1'b1, faultActive)
    faultResetInput <= 0;
    powerPresent <= 0;
    cyc(25);
    powerPresent <= 1;
    cyc(5); `CHK("power cycle reset", 1'b0, faultActive)
    motorCurPermil <= 16'h07D0;
    speedNoSlip <= 16'h0032;
    cyc(3); `CHK("ao cur fs", 12'hFFF, aoMotorCurrent)
    `CHK("ao spd fs", 12'hFFF, aoMotorSpeed)
    {motorCurPermil, speedNoSlip} <= '0;
    cyc(3); `CHK("ao cur 0", 12'h000, aoMotorCurrent)
    `CHK("ao spd 0", 12'h000, aoMotorSpeed)
    apb(1, 8'h00, 32'h312);
    cyc(3); `CHK("ao spd 4mA", 12'h333, aoMotorSpeed)
    apb(1, 8'h1C, 32'h0ADB);
    setpointPct <= 16'h0065;
    for (int k = 0; k < 2; k++) begin
      motorThermPct <= k ? 16'h00C7 : 16'h00C8;
      feedbackPct <= k ? 16'h0002 : 16'h0000;
      driveCurPct <= k ? 16'h0009 : 16'h000A;
      cyc(4);
      `CHK("therm level", k == 0, logicOut[0])
      `CHK("feedback_limit_flag", k == 0, logicOut[1])
      `CHK("cur level", k == 0, logicOut[2])
    end
    apb(1, 8'h00, 32'h11E);
    faultCause <= 24'h020000;
    cyc(3);
    faultCause <= '0;
    cyc(30); `CHK("auto restart", 1'b0, faultActive)
    conclude();
  end
endmodule // dso_top_tb_top
`default_nettype wire
